// file: src/twi_params.svh
`ifndef TWI_PARAMS_SVH
`define TWI_PARAMS_SVH

// core clock period and longest spike the line filter must reject
`define TWI_MCLK_NS 4
`define TWI_SPIKE_NS 50
// least time rounds up to whole core cycles
`define TWI_SPIKE_CYC ((`TWI_SPIKE_NS + `TWI_MCLK_NS - 1) / `TWI_MCLK_NS)
`define TWI_FILT_W 4

// byte framing
`define TWI_BYTE_BITS 4'h8
`define TWI_MAX_BYTES 4'h8

// slave address layout
`define TWI_ADDR_FIXED 2'h3
`define TWI_GCALL_ADDR 7'h00
`define TWI_DIR_READ 1'h1

// level of a released line
`define TWI_LINE_IDLE 1'h1

`endif

// file: src/twi_pkg.sv
package twi_pkg;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_HOLD,
    ST_RX_ACK,
    ST_TX_LOAD,
    ST_TX,
    ST_TX_ACK,
    ST_IGNORE
  } twi_state_t;

endpackage

// file: src/line_filter.sv
`timescale 1ns/10ps
`default_nettype none
`include "twi_params.svh"

module line_filter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raw_i,
  output logic filt_o
);

  logic meta_q;
  logic sync_q;
  logic out_q;
  logic [`TWI_FILT_W-1:0] cnt_q;

  // a new level is taken only after it has held for the spike time
  wire differ = sync_q != out_q;
  wire settled = cnt_q == `TWI_FILT_W'(`TWI_SPIKE_CYC - 1);

  // two-flop synchroniser, then the stability counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= `TWI_LINE_IDLE;
      sync_q <= `TWI_LINE_IDLE;
      out_q <= `TWI_LINE_IDLE;
      cnt_q <= '0;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
      cnt_q <= (differ && !settled) ? cnt_q + `TWI_FILT_W'(1) : '0;
      if (differ && settled) begin
        out_q <= sync_q;
      end
    end
  end

  assign filt_o = out_q;

endmodule

`default_nettype wire

// file: src/bit_clock_toggle.sv
`timescale 1ns/10ps
`default_nettype none

module bit_clock_toggle (
  input wire logic sck_i,
  input wire logic rst_i,
  output logic toggle_o
);

  logic toggle_q;

  // flips on every rising serial clock; the core sees each flip as one bit
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
    end
  end

  assign toggle_o = toggle_q;

endmodule

`default_nettype wire

// file: src/two_wire_slave_interface.sv
// How it works
// - both lines driven only open-drain; released lines idle high
// - works up to fast-mode bit rate; master never clocks faster
// - data line changes only while the clock line is low
// - data falling with clock high is START; rising is STOP
// - repeated START keeps bus busy and acts like a first START
// - bytes are eight bits, MSB first, then one acknowledge bit
// - at most eight bytes per transfer to this device
// - slave may hold clock low while not ready; master waits
// - master clocks the ack bit; the transmitter releases data
// - receiver acknowledges by holding data low through the ack high
// - unmatched address leaves data high in the ack slot
// - receiver that cannot take more bytes not-acknowledges the next
// - master nacks the last read byte; device then releases data
// - first byte is seven address bits then direction, one is read
// - write data is sampled on each rising serial clock
// - device acknowledges its address and each accepted write byte
// - both eight-byte and two-byte command transfers are accepted
// - spikes on the data line are filtered out
// - a read is a register-address write followed by a read
// - own address is two ones, four memory bits, one pin bit
// - the all-zero general call address is also acknowledged when the direction is write
// - any START resets the bus logic to expect an address
`timescale 1ns/10ps
`default_nettype none
`include "twi_params.svh"

module two_wire_slave_interface (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic HARDWIRED_ADDRESS_PIN_I,
  input wire logic [3:0] OTP_ADDR_I,
  output logic [7:0] RX_DATA_O,
  output logic RX_VALID_O,
  output logic RX_FIRST_O,
  input wire logic RX_READY_I,
  output logic GENERAL_CALL_O,
  input wire logic [7:0] TX_DATA_I,
  input wire logic TX_VALID_I,
  output logic TX_TAKEN_O,
  output logic FRAME_END_O,
  output logic BUS_BUSY_O
);

  twi_pkg::twi_state_t state_q, state_d;
  logic [7:0] sr_q, sr_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [3:0] byte_cnt_q, byte_cnt_d;
  logic rw_q, rw_d;
  logic gcall_q, gcall_d;
  logic nak_q, nak_d;
  logic sda_oe_q, sda_oe_d;
  logic scl_oe_q;
  logic busy_q, busy_d;
  logic first_q, first_d;
  logic rx_valid;
  logic tx_take;
  logic [7:0] rx_data_q;
  logic rx_valid_q;
  logic rx_first_q;
  logic sda_f, scl_f, hw_f;
  logic sda_prev_q, scl_prev_q;
  logic toggle;
  logic tg_meta_q, tg_sync_q, tg_prev_q;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  // synchronised and spike-filtered lines and address pin
  line_filter u_sda_filt (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .raw_i(SDA_I),
    .filt_o(sda_f)
  );
  line_filter u_scl_filt (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .raw_i(SCK_I),
    .filt_o(scl_f)
  ); // filter far shorter than a fast-mode clock phase
  line_filter u_hw_filt (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .raw_i(HARDWIRED_ADDRESS_PIN_I),
    .filt_o(hw_f)
  );

  // rising serial clock counted in the link's own domain
  bit_clock_toggle u_bit_tog (
    .sck_i(SCK_I),
    .rst_i(RESET_I),
    .toggle_o(toggle)
  );

  // toggle crossing and previous line levels
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      tg_meta_q <= 1'b0;
      tg_sync_q <= 1'b0;
      tg_prev_q <= 1'b0;
      sda_prev_q <= `TWI_LINE_IDLE;
      scl_prev_q <= `TWI_LINE_IDLE;
    end else begin
      tg_meta_q <= toggle;
      tg_sync_q <= tg_meta_q;
      tg_prev_q <= tg_sync_q;
      sda_prev_q <= sda_f;
      scl_prev_q <= scl_f;
    end
  end

  // bus conditions and bit events
  wire bit_evt = tg_sync_q ^ tg_prev_q;
  wire start_det = scl_f && scl_prev_q && sda_prev_q && !sda_f;
  wire stop_det = scl_f && scl_prev_q && !sda_prev_q && sda_f;
  wire scl_fall = scl_prev_q && !scl_f;

  // address match and byte state
  wire [6:0] own_addr = {`TWI_ADDR_FIXED, OTP_ADDR_I, hw_f};
  wire addr_self = sr_q[7:1] == own_addr;
  wire addr_gc = sr_q[7:1] == `TWI_GCALL_ADDR && sr_q[0] != `TWI_DIR_READ;
  wire byte_full = bit_cnt_q == `TWI_BYTE_BITS;
  wire rx_over = byte_cnt_q == `TWI_MAX_BYTES;
  wire [7:0] sr_shift = {sr_q[6:0], sda_f}; // MSB arrives first

  // protocol state machine
  always_comb begin
    state_d = state_q;
    sr_d = sr_q;
    bit_cnt_d = bit_cnt_q;
    byte_cnt_d = byte_cnt_q;
    rw_d = rw_q;
    gcall_d = gcall_q;
    nak_d = nak_q;
    sda_oe_d = sda_oe_q;
    busy_d = busy_q;
    first_d = first_q;
    rx_valid = 1'b0;
    tx_take = 1'b0;
    if (start_det) begin
      // first or repeated START: back to expecting an address
      state_d = twi_pkg::ST_ADDR;
      bit_cnt_d = '0;
      byte_cnt_d = '0;
      gcall_d = 1'b0;
      sda_oe_d = 1'b0;
      busy_d = 1'b1;
    end else if (stop_det) begin
      state_d = twi_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
      gcall_d = 1'b0;
      busy_d = 1'b0;
    end else begin
      unique case (state_q)
        twi_pkg::ST_IDLE, twi_pkg::ST_IGNORE: begin
        end
        twi_pkg::ST_ADDR: begin
          if (bit_evt && !byte_full) begin
            sr_d = sr_shift;
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          if (scl_fall && byte_full) begin
            rw_d = sr_q[0];
            gcall_d = addr_gc;
            if (addr_self || addr_gc) begin
              state_d = twi_pkg::ST_ADDR_ACK;
              sda_oe_d = 1'b1;
            end else begin
              state_d = twi_pkg::ST_IGNORE;
            end
          end
        end
        twi_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            bit_cnt_d = '0;
            first_d = 1'b1;
            state_d = (rw_q == `TWI_DIR_READ) ? twi_pkg::ST_TX_LOAD : twi_pkg::ST_RX;
          end
        end
        twi_pkg::ST_RX: begin
          if (bit_evt && !byte_full) begin
            sr_d = sr_shift;
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          if (scl_fall && byte_full) begin
            state_d = twi_pkg::ST_RX_HOLD;
          end
        end
        twi_pkg::ST_RX_HOLD: begin
          if (rx_over) begin
            state_d = twi_pkg::ST_RX_ACK; // data left high
          end else if (RX_READY_I) begin
            rx_valid = 1'b1;
            byte_cnt_d = byte_cnt_q + 4'h1;
            first_d = 1'b0;
            sda_oe_d = 1'b1;
            state_d = twi_pkg::ST_RX_ACK;
          end
        end
        twi_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            bit_cnt_d = '0;
            state_d = twi_pkg::ST_RX;
          end
        end
        twi_pkg::ST_TX_LOAD: begin
          if (TX_VALID_I) begin
            tx_take = 1'b1;
            sr_d = TX_DATA_I;
            sda_oe_d = !TX_DATA_I[7];
            bit_cnt_d = '0;
            state_d = twi_pkg::ST_TX;
          end
        end
        twi_pkg::ST_TX: begin
          if (bit_evt && !byte_full) begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          if (scl_fall && byte_full) begin
            sda_oe_d = 1'b0;
            nak_d = 1'b0;
            state_d = twi_pkg::ST_TX_ACK;
          end else if (scl_fall) begin
            sr_d = {sr_q[6:0], 1'b0};
            sda_oe_d = !sr_q[6];
          end
        end
        twi_pkg::ST_TX_ACK: begin
          if (bit_evt) begin
            nak_d = sda_f;
          end
          if (scl_fall) begin
            state_d = nak_q ? twi_pkg::ST_IGNORE : twi_pkg::ST_TX_LOAD;
          end
        end
      endcase
    end
  end

  // states in which the user side holds up the next bit
  function automatic logic stretch_state(input twi_pkg::twi_state_t s);
    return s == twi_pkg::ST_TX_LOAD || s == twi_pkg::ST_RX_HOLD;
  endfunction

  // stretch while a byte waits; let go one cycle after data is set up
  wire scl_oe_d = stretch_state(state_d) || stretch_state(state_q);

  // state registers
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_q <= twi_pkg::ST_IDLE;
      sr_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= 4'h0;
      rw_q <= 1'b0;
      gcall_q <= 1'b0;
      nak_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      busy_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sr_q <= sr_d;
      bit_cnt_q <= bit_cnt_d;
      byte_cnt_q <= byte_cnt_d;
      rw_q <= rw_d;
      gcall_q <= gcall_d;
      nak_q <= nak_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      busy_q <= busy_d;
      first_q <= first_d;
    end
  end

  // received byte handed to the user side
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_first_q <= 1'b0;
    end else begin
      rx_valid_q <= rx_valid;
      if (rx_valid) begin
        rx_data_q <= sr_q;
        rx_first_q <= first_q;
      end
    end
  end

  // open-drain pins: only ever pull low
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_q;
  assign SCK_O = 1'b0;
  assign SCK_OE_O = scl_oe_q;
  assign RX_DATA_O = rx_data_q;
  assign RX_VALID_O = rx_valid_q;
  assign RX_FIRST_O = rx_first_q;
  assign GENERAL_CALL_O = gcall_q;
  assign TX_TAKEN_O = tx_take;
  assign FRAME_END_O = stop_det;
  assign BUS_BUSY_O = busy_q;

  // checks
  sequence s_start;
    start_det;
  endsequence
  sequence s_tx_nak_end;
    state_q == twi_pkg::ST_TX_ACK && nak_q && scl_fall && !start_det && !stop_det;
  endsequence

  a_start_to_addr: assert property (s_start |=> state_q == twi_pkg::ST_ADDR && busy_q
    && bit_cnt_q == 4'h0 && !sda_oe_q) else $error("start did not restart address");
  a_stop_to_idle: assert property (stop_det && !start_det |=> state_q == twi_pkg::ST_IDLE
    && !busy_q && !sda_oe_q) else $error("stop did not free the bus");
  a_data_low_clock: assert property ($changed(sda_oe_q) && !$past(start_det || stop_det)
    |-> !scl_f) else $error("data moved while clock high");
  a_unmatched_release: assert property (state_q == twi_pkg::ST_IGNORE |-> !sda_oe_q)
    else $error("data driven after unmatched address");
  a_overflow_nak: assert property (state_q == twi_pkg::ST_RX_HOLD && rx_over
    |=> state_q != twi_pkg::ST_RX_ACK || !sda_oe_q) else $error("ninth byte acked");
  a_rx_ack_hold: assert property (rx_valid |=> sda_oe_q && rx_valid_q
    && rx_data_q == $past(sr_q)) else $error("accepted byte not acked");
  a_stretch_hold: assert property (state_q == twi_pkg::ST_RX_HOLD && !rx_over && !RX_READY_I
    && !start_det && !stop_det |=> scl_oe_q && !rx_valid_q) else $error("no stretch");
  a_tx_release: assert property (state_q == twi_pkg::ST_TX_ACK |-> !sda_oe_q)
    else $error("transmitter held data in ack slot");
  a_read_nak_end: assert property (s_tx_nak_end |=> state_q == twi_pkg::ST_IGNORE
    ##1 !sda_oe_q) else $error("data not released after master nak");
  a_msb_first: assert property (state_q == twi_pkg::ST_TX_LOAD && TX_VALID_I && !start_det
    && !stop_det |=> sda_oe_q == !$past(TX_DATA_I[7])) else $error("msb not first");
  a_sample_rise: assert property (state_q == twi_pkg::ST_RX && bit_evt && !byte_full
    && !start_det && !stop_det |=> sr_q[0] == $past(sda_f)) else $error("bit missed");
  a_dir_read: assert property (state_q == twi_pkg::ST_ADDR_ACK && scl_fall && !start_det
    && !stop_det && rw_q |=> state_q == twi_pkg::ST_TX_LOAD) else $error("read not taken");
  a_byte_limit: assert property (rx_valid |-> byte_cnt_q < `TWI_MAX_BYTES)
    else $error("more than eight bytes accepted");
  a_setup_release: assert property ($fell(scl_oe_q) |-> $stable(sda_oe_q))
    else $error("data changed as clock was released");
  a_open_drain: assert property (SDA_O == 1'b0 && SCK_O == 1'b0)
    else $error("line driven high");

endmodule

`default_nettype wire

// file: sim/twi_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// bus master: open-drain pulls on both lines, timed from its own clock
module twi_master_model (
  input wire logic lclk_i,
  input wire logic sck_i,
  input wire logic sda_i,
  output logic sck_low_o,
  output logic sda_low_o
);
  localparam int LO = 50; // low phase ticks, well above the 20-cycle minimum
  localparam int HI = 30; // phases shortened to keep the run short

  // both lines released, bus idles high
  initial begin
    sck_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk_i);
  endtask

  // release clock, wait while the slave stretches it, hold high phase
  task automatic rise();
    sck_low_o <= 1'b0;
    for (int k = 0; k < 5000 && sck_i !== 1'b1; k++) tick(1);
    tick(HI);
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    tick(2);
    sda_low_o <= 1'b0;
    tick(LO - 2);
    rise();
    sda_low_o <= 1'b1;
    tick(HI);
    sck_low_o <= 1'b1;
  endtask

  // stop: data rises while clock high, ends a transfer
  task automatic stop();
    tick(2);
    sda_low_o <= 1'b1;
    tick(LO - 2);
    rise();
    sda_low_o <= 1'b0;
    tick(HI);
  endtask

  // one bit slot: data changes only while clock is low
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_low_o <= ~b;
    tick(LO - 2);
    rise();
    r = sda_i;
    sck_low_o <= 1'b1;
  endtask

  // byte msb first, then the acknowledge slot clocked by the master
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, ak);
  endtask

  // short low pulse on data while clock is high
  task automatic spike();
    tick(1);
    sda_low_o <= 1'b1;
    tick(1);
    sda_low_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: sim/tb_two_wire_slave_interface.sv
`timescale 1ns/10ps
`default_nettype none

module tb_two_wire_slave_interface;
  logic MCLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic lclk = 1'b0;
  logic RX_READY_I = 1'b1;
  logic TX_VALID_I = 1'b1;
  logic HARDWIRED_ADDRESS_PIN_I = 1'b0;
  logic [3:0] OTP_ADDR_I = 4'h0;
  logic [7:0] TX_DATA_I = 8'h00;
  logic SCK_O, SCK_OE_O, SDA_O, SDA_OE_O, RX_VALID_O, RX_FIRST_O;
  logic GENERAL_CALL_O, TX_TAKEN_O, FRAME_END_O, BUS_BUSY_O;
  logic [7:0] RX_DATA_O;
  logic m_sck_low, m_sda_low, ak;
  logic [7:0] q;
  logic [6:0] own;
  logic [7:0] rxq[$], txq[$];
  logic fq[$];
  int fail_count = 0, tests_run = 0, cyc = 0, ends = 0, slow = 1, e0;
  // wired-and with pull-ups
  wire sck_w = ~(m_sck_low | SCK_OE_O);
  wire sda_w = ~(m_sda_low | SDA_OE_O);

  always #2 MCLK_I = ~MCLK_I;
  initial #1.7 forever #6 lclk = ~lclk;

  two_wire_slave_interface i_two_wire_slave_interface (
    .MCLK_I(MCLK_I), .RESET_I(RESET_I), .SCK_I(sck_w), .SCK_O(SCK_O),
    .SCK_OE_O(SCK_OE_O), .SDA_I(sda_w), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
    .HARDWIRED_ADDRESS_PIN_I(HARDWIRED_ADDRESS_PIN_I), .OTP_ADDR_I(OTP_ADDR_I),
    .RX_DATA_O(RX_DATA_O), .RX_VALID_O(RX_VALID_O), .RX_FIRST_O(RX_FIRST_O),
    .RX_READY_I(RX_READY_I), .GENERAL_CALL_O(GENERAL_CALL_O), .TX_DATA_I(TX_DATA_I),
    .TX_VALID_I(TX_VALID_I), .TX_TAKEN_O(TX_TAKEN_O), .FRAME_END_O(FRAME_END_O),
    .BUS_BUSY_O(BUS_BUSY_O));

  twi_master_model i_twi_master_model (
    .lclk_i(lclk), .sck_i(sck_w), .sda_i(sda_w), .sck_low_o(m_sck_low),
    .sda_low_o(m_sda_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // random user side readiness and read data, plus the hang limit
  always @(posedge MCLK_I) begin
    cyc++;
    RX_READY_I <= ($urandom % slow) == 0;
    TX_VALID_I <= ($urandom % 4) != 0;
    TX_DATA_I <= 8'($urandom);
    if (cyc == 95000) begin
      fail_count++;
      test_done();
    end
  end

  // record user side events between clock edges
  always @(negedge MCLK_I) begin
    if (RX_VALID_O === 1'b1) rxq.push_back(RX_DATA_O);
    if (RX_VALID_O === 1'b1) fq.push_back(RX_FIRST_O);
    if (TX_TAKEN_O === 1'b1) txq.push_back(TX_DATA_I);
    if (FRAME_END_O === 1'b1) ends++;
  end

  // addressed write of n bytes, closed by a stop
  task automatic wr(input logic [6:0] a, input int n, input logic exp_ack);
    logic [7:0] d;
    e0 = ends;
    rxq.delete();
    fq.delete();
    i_twi_master_model.start();
    i_twi_master_model.byte_x({a, 1'b0}, 1'b1, q, ak);
    check(ak, !exp_ack);
    check(BUS_BUSY_O, 1'b1);
    if (exp_ack) check(GENERAL_CALL_O, a == 7'h00);
    for (int i = 0; i < n && exp_ack; i++) begin
      d = 8'($urandom);
      i_twi_master_model.byte_x(d, 1'b1, q, ak);
      check(ak, i >= 8);
      check(8'(rxq.size()), i < 8);
      if (i < 8) check(rxq.pop_front(), d);
      if (i < 8) check(fq.pop_front(), i == 0);
    end
    i_twi_master_model.stop();
    check(8'(ends - e0), 1);
    check({BUS_BUSY_O, SCK_OE_O, SDA_OE_O, SCK_O, SDA_O, GENERAL_CALL_O}, 0);
  endtask

  // register pointer write, repeated start, read n bytes, last refused
  task automatic rd(input int n);
    i_twi_master_model.start();
    i_twi_master_model.byte_x({own, 1'b0}, 1'b1, q, ak);
    check(ak, 1'b0);
    i_twi_master_model.byte_x(8'h81, 1'b1, q, ak);
    check(ak, 1'b0);
    txq.delete();
    i_twi_master_model.start();
    i_twi_master_model.byte_x({own, 1'b1}, 1'b1, q, ak);
    check(ak, 1'b0);
    for (int i = 0; i < n; i++) begin
      i_twi_master_model.byte_x(8'hFF, i == n - 1, q, ak);
      check(q, (txq.size() > 0) ? txq.pop_front() : 8'hXX);
    end
    e0 = ends;
    i_twi_master_model.stop();
    check(8'(ends - e0), 1);
    check(8'(txq.size()), 0);
  endtask

  initial begin
    void'($urandom(32'hFDCD));
    @(posedge MCLK_I);
    OTP_ADDR_I <= 4'($urandom);
    HARDWIRED_ADDRESS_PIN_I <= 1'($urandom);
    repeat (16) @(posedge MCLK_I);
    RESET_I <= 1'b0;
    repeat (25) @(posedge MCLK_I);
    own = {2'b11, OTP_ADDR_I, HARDWIRED_ADDRESS_PIN_I};
    wr(own, 9, 1'b1);
    slow = 200;
    wr(own, 2, 1'b1);
    slow = 1;
    for (int k = 0; k < 7; k += 3) wr(own ^ 7'(1 << k), 1, 1'b0);
    wr(7'h00, 1, 1'b1);
    // general call with read direction stays unanswered
    i_twi_master_model.start();
    i_twi_master_model.byte_x(8'h01, 1'b1, q, ak);
    check(ak, 1'b1);
    i_twi_master_model.stop();
    rd(3);
    // start in mid-byte brings back the address phase
    i_twi_master_model.start();
    i_twi_master_model.byte_x({own, 1'b0}, 1'b1, q, ak);
    for (int k = 0; k < 4; k++) i_twi_master_model.bit_x(1'b0, ak);
    wr(own, 2, 1'b1);
    // a short data glitch on an idle bus is no bus condition
    e0 = ends;
    i_twi_master_model.spike();
    repeat (40) @(posedge MCLK_I);
    check(8'(ends - e0), 0);
    check(BUS_BUSY_O, 1'b0);
    test_done();
  end
endmodule

`default_nettype wire
